/* File: spi_far_end.sv */
module spi_far_end (
  // Bench control
  input  wire logic        i_drive,
  input  wire logic        i_cpol,
  input  wire logic [4:0]  i_bits,
  input  wire logic [15:0] i_tx,
  // Serial lines
  input  wire logic        i_sck,
  input  wire logic        i_sdo,
  output logic             o_sck,
  output logic             o_sdi,
  output logic [15:0]      o_rx,
  output int               o_edges
);
  timeunit 1ns;
  timeprecision 1ns;

  logic act;

  // Edges are taken against the idle level, so one model fits both
  // polarities.
  assign act = (i_drive ? o_sck : i_sck) ^ i_cpol;

  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b0;
    clear();
  end

  task automatic clear();
    o_edges = 0;
    o_rx = 16'h0000;
  endtask

  // The link clock stands still between frames.
  task automatic run();
    #13;
    repeat (i_bits) begin
      #160 o_sck = ~i_cpol;
      #160 o_sck = i_cpol;
    end
  endtask

  always @(posedge act) begin
    if (o_edges < int'(i_bits)) begin
      o_sdi = i_tx[i_bits - 5'h01 - 5'(o_edges)];
    end
    o_edges = o_edges + 1;
  end

  // Release is late so that the last bit still meets the sampler.
  always @(negedge act) begin
    o_rx = {o_rx[14:0], i_sdo};
    if (o_edges >= int'(i_bits)) begin
      o_sdi <= #200 ~o_sdi;
    end
  end
endmodule // spi_far_end

/* File: spi_port.sv */
`include "spi_port_consts.svh"

// Overview of operation
// (RULE_01) Enable bit activates port and claims pins.
// (RULE_02) Idle-stop halts port during device idle.
// (RULE_03) Unread buffer: new word dropped, overflow set.
// (RULE_04) Buffer write sets transmit full; load clears.
// (RULE_05) Receive full set on move, cleared on read.
// (RULE_06) Master clock-pin disable stops internal clock.
// (RULE_07) Data-out disable releases the data pin.
// (RULE_08) Word size selects 16 or 8 pulses.
// (RULE_09) Changing word size resets the port.
// (RULE_10) Shift out bit 7/15, in bit 0.
// (RULE_11) Master samples at middle or end.
// (RULE_12) Software keeps sample phase clear as slave.
// (RULE_13) Clock-edge bit chooses output change edge.
// (RULE_14) Software clears clock-edge bit when framed.
// (RULE_15) Slave select pin used when enabled.
// (RULE_16) Polarity bit sets serial clock idle level.
// (RULE_17) Master-enable selects master or slave.
// (RULE_18) Secondary prescale divides by 8 minus code.
// (RULE_19) Primary prescale divides by 1,4,16,64.
// (RULE_20) Framed enable turns select pin into sync.
// (RULE_21) Sync direction and polarity bits obeyed.
// (RULE_22) Sync pulse coincides with or precedes bit.
// (RULE_23) Buffer address splits into transmit and receive.
// (RULE_24) Master clocks only with data to send.
// (RULE_25) Serial clock is system clock over prescales; a product of 1 gives system clock over 2.
module spi_port (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_reset,
  // Register port
  input  wire spi_port_pkg::reg_req_t  i_bus,
  output wire logic [15:0]             o_rdata,
  // Device power state
  input  wire logic                    i_idle,
  // Serial pins
  input  wire logic                    i_sck,
  input  wire logic                    i_sdi,
  input  wire logic                    i_fs,
  output wire spi_port_pkg::pin_drive_t o_pins,
  output wire logic                    o_port_active
);

  spi_port_pkg::port_state_t r;
  spi_port_pkg::port_state_t n;

  // ---------------------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------------------
  logic        halt;
  logic        ext_clk;
  logic        cke_eff;
  logic [3:0]  msb;
  logic [3:0]  sec_div;
  logic [9:0]  period;
  logic [9:0]  period_eff;
  logic [9:0]  half;
  logic [15:0] sr_shift;
  logic        lead_edge;
  logic        trail_edge;
  logic        fs_active;
  logic        sel_ok;
  logic        word_chg;
  logic        mode_chg;

  // Idle-stop freeze.
  // (RULE_02) halt in idle
  assign halt = r.port_enable & r.idle_stop & i_idle;
  // Slaves, and masters with the clock pin released, follow external edges.
  // (RULE_06) external clocking
  // (RULE_17) master or slave
  assign ext_clk = ~r.pri.master_enable | r.pri.clock_pin_disable;
  // (RULE_14) edge bit ignored framed
  assign cke_eff = r.pri.clock_edge & ~r.framed_enable;
  // (RULE_08) word length
  assign msb = r.pri.word_size_select ? `MSB_WORD : `MSB_BYTE;
  // (RULE_18) secondary ratio
  assign sec_div = `SEC_BASE - {1'b0, r.pri.secondary_prescale};
  // (RULE_19) primary ratio
  // (RULE_25) product of ratios
  assign period = {6'h00, sec_div}
                  << {~r.pri.primary_prescale, 1'b0};
  // A full ratio of 1 cannot toggle a registered pin, so it runs at half rate.
  assign period_eff = (period < `PERIOD_MIN) ? `PERIOD_MIN : period;
  assign half = {1'b0, period_eff[9:1]};
  // (RULE_10) shift into bit 0
  assign sr_shift = {r.serial_shift_register[14:0], r.sdi_s2};
  // (RULE_16) polarity of edges
  assign lead_edge = r.pri.clock_polarity ? (~r.sck_s2 & r.sck_prev)
                                          : (r.sck_s2 & ~r.sck_prev);
  assign trail_edge = r.pri.clock_polarity ? (r.sck_s2 & ~r.sck_prev)
                                           : (~r.sck_s2 & r.sck_prev);
  // (RULE_21) sync polarity
  assign fs_active = r.frame_sync_polarity ? r.fs_s2 : ~r.fs_s2;
  // (RULE_15) active-low select
  assign sel_ok = ~(~r.pri.master_enable & r.pri.slave_select_enable &
                    ~r.framed_enable) | ~r.fs_s2;
  assign word_chg = i_bus.wr & (i_bus.addr == `ADDR_CTRL_PRI) &
                    (i_bus.wdata[`PRI_WS_BIT] != r.pri.word_size_select);
  // Moving between internal and external clocking mid-word would leave
  // the engine in a state meant for the other source, so it restarts.
  // (RULE_24) no stale clocking
  assign mode_chg = i_bus.wr & (i_bus.addr == `ADDR_CTRL_PRI) &
                    ((~i_bus.wdata[`PRI_MST_BIT] |
                      i_bus.wdata[`PRI_CPD_BIT]) != ext_clk);

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic        change_ev;
    logic        sample_ev;
    logic        do_load;
    logic        do_done;
    logic        rov_set;
    logic        rbf_set;
    logic        fs_drive;
    logic        sck_act;
    logic [15:0] done_word;
    n = r;
    change_ev = 1'b0;
    sample_ev = 1'b0;
    do_load = 1'b0;
    do_done = 1'b0;
    rov_set = 1'b0;
    rbf_set = 1'b0;
    fs_drive = 1'b0;
    sck_act = 1'b0;
    done_word = r.serial_shift_register;

    n.sck_s1 = i_sck;
    n.sck_s2 = r.sck_s1;
    n.sck_prev = r.sck_s2;
    n.sdi_s1 = i_sdi;
    n.sdi_s2 = r.sdi_s1;
    n.fs_s1 = i_fs;
    n.fs_s2 = r.fs_s1;

    if (!r.port_enable) begin
      n.state = spi_port_pkg::ST_IDLE;
      n.cnt = 10'h000;
      n.bitn = 5'h00;
      n.loaded = 1'b0;
      n.frame_go = 1'b0;
    end else if (!halt) begin
      case (r.state)
        spi_port_pkg::ST_IDLE: begin
          if (ext_clk) begin
            n.state = spi_port_pkg::ST_SHIFT;
          // (RULE_24) clock only with data
          end else if (r.transmit_buffer_full) begin
            do_load = 1'b1;
            n.cnt = 10'h000;
            n.bitn = 5'h00;
            // (RULE_22) leading sync period
            n.state = (r.framed_enable & ~r.frame_sync_edge) ?
                      spi_port_pkg::ST_PRE : spi_port_pkg::ST_SHIFT;
          end
        end
        spi_port_pkg::ST_PRE: begin
          if (r.cnt == period_eff - 10'h001) begin
            n.cnt = 10'h000;
            n.state = spi_port_pkg::ST_SHIFT;
          end else begin
            n.cnt = r.cnt + 10'h001;
          end
        end
        spi_port_pkg::ST_SHIFT: begin
          if (ext_clk) begin
            // (RULE_13) external change edge
            change_ev = cke_eff ? trail_edge : lead_edge;
            sample_ev = cke_eff ? lead_edge : trail_edge;
            if (!sel_ok) begin
              n.bitn = 5'h00;
              n.frame_go = 1'b0;
            end else begin
              if (r.bitn == 5'h00 && !r.loaded && r.transmit_buffer_full) begin
                do_load = 1'b1;
                n.loaded = 1'b1;
              end
              // (RULE_20) wait for frame sync
              if (r.framed_enable && r.frame_sync_direction &&
                  r.bitn == 5'h00 && fs_active) begin
                n.frame_go = 1'b1;
              end
              if (r.framed_enable && r.frame_sync_direction && !r.frame_go) begin
                change_ev = 1'b0;
                sample_ev = 1'b0;
              end
              if (sample_ev && !do_load) begin
                n.bitn = r.bitn + 5'h01;
                if (r.bitn[3:0] == msb) begin
                  do_done = 1'b1;
                  done_word = sr_shift;
                  n.bitn = 5'h00;
                  n.loaded = 1'b0;
                  n.frame_go = 1'b0;
                end
              end
            end
          end else begin
            // (RULE_13) change at bit boundary
            change_ev = (r.cnt == 10'h000);
            // (RULE_11) middle or end sample
            sample_ev = r.pri.input_sample_phase ?
                        (r.cnt == period_eff - 10'h001) : (r.cnt == half);
            n.cnt = r.cnt + 10'h001;
            if (r.cnt == period_eff - 10'h001) begin
              n.cnt = 10'h000;
              n.bitn = r.bitn + 5'h01;
              if (r.bitn[3:0] == msb) begin
                do_done = 1'b1;
                done_word = sample_ev ? sr_shift : r.serial_shift_register;
                n.bitn = 5'h00;
                n.state = spi_port_pkg::ST_IDLE;
                // Back-to-back words keep the clock running without a gap, except where a leading sync period comes first.
                if (r.transmit_buffer_full) begin
                  do_load = 1'b1;
                  n.state = (r.framed_enable & ~r.frame_sync_edge) ?
                            spi_port_pkg::ST_PRE : spi_port_pkg::ST_SHIFT;
                end
              end
            end
          end
          // (RULE_10) out of bit 7 or 15
          if (change_ev) begin
            n.sdo = r.serial_shift_register[msb];
          end
          if (sample_ev && !do_load) begin
            n.serial_shift_register = sr_shift;
          end
        end
        default: n.state = spi_port_pkg::ST_IDLE;
      endcase
    end

    // (RULE_04) move clears full
    if (do_load) begin
      n.serial_shift_register = r.transmit_holding_register;
      n.sdo = r.transmit_holding_register[msb];
      n.transmit_buffer_full = 1'b0;
    end
    if (do_done) begin
      // (RULE_03) discard on overflow
      if (r.receive_buffer_full) begin
        rov_set = 1'b1;
      // (RULE_05) move sets full
      end else begin
        rbf_set = 1'b1;
        n.receive_holding_register = r.pri.word_size_select ? done_word :
                                     {8'h00, done_word[7:0]};
      end
    end

    // -------------------------------------------------------------------------
    // Register port
    // -------------------------------------------------------------------------
    n.rdata = 16'h0000;
    if (i_bus.rd) begin
      if (i_bus.addr == `ADDR_STATUS) begin
        n.rdata[`STAT_EN_BIT] = r.port_enable;
        n.rdata[`STAT_SIDL_BIT] = r.idle_stop;
        n.rdata[`STAT_ROV_BIT] = r.receive_overflow_flag;
        n.rdata[`STAT_TBF_BIT] = r.transmit_buffer_full;
        n.rdata[`STAT_RBF_BIT] = r.receive_buffer_full;
      end else if (i_bus.addr == `ADDR_CTRL_PRI) begin
        n.rdata = {3'h0, r.pri};
      end else if (i_bus.addr == `ADDR_CTRL_FRM) begin
        n.rdata[`FRM_EN_BIT] = r.framed_enable;
        n.rdata[`FRM_DIR_BIT] = r.frame_sync_direction;
        n.rdata[`FRM_POL_BIT] = r.frame_sync_polarity;
        n.rdata[`FRM_EDGE_BIT] = r.frame_sync_edge;
      end else begin
        // (RULE_23) read receive side
        n.rdata = r.receive_holding_register;
      end
    end
    // (RULE_05) read clears, set wins
    if (i_bus.rd && i_bus.addr == `ADDR_BUFFER) begin
      n.receive_buffer_full = 1'b0;
    end
    if (rbf_set) begin
      n.receive_buffer_full = 1'b1;
    end
    // (RULE_03) software clear, set wins
    if (i_bus.wr && i_bus.addr == `ADDR_STATUS &&
        !i_bus.wdata[`STAT_ROV_BIT]) begin
      n.receive_overflow_flag = 1'b0;
    end
    if (rov_set) begin
      n.receive_overflow_flag = 1'b1;
    end
    if (i_bus.wr) begin
      if (i_bus.addr == `ADDR_STATUS) begin
        // (RULE_01) enable bit
        n.port_enable = i_bus.wdata[`STAT_EN_BIT];
        n.idle_stop = i_bus.wdata[`STAT_SIDL_BIT];
      end else if (i_bus.addr == `ADDR_CTRL_PRI) begin
        n.pri = i_bus.wdata[`PRI_WIDTH-1:0];
      end else if (i_bus.addr == `ADDR_CTRL_FRM) begin
        n.framed_enable = i_bus.wdata[`FRM_EN_BIT];
        n.frame_sync_direction = i_bus.wdata[`FRM_DIR_BIT];
        n.frame_sync_polarity = i_bus.wdata[`FRM_POL_BIT];
        n.frame_sync_edge = i_bus.wdata[`FRM_EDGE_BIT];
      end else begin
        // (RULE_04) write sets full
        // (RULE_23) write transmit side
        n.transmit_holding_register = i_bus.wdata;
        n.transmit_buffer_full = 1'b1;
      end
    end
    // A size change mid-word would leave a half shifted word, so start over.
    // A clock source change would otherwise clock a stale word with no data.
    // (RULE_09) size change resets
    // (RULE_24) source change restarts
    if (word_chg || mode_chg) begin
      n.state = spi_port_pkg::ST_IDLE;
      n.cnt = 10'h000;
      n.bitn = 5'h00;
      n.loaded = 1'b0;
      n.frame_go = 1'b0;
    end
    // Flags clear only on a size change; a source change keeps them.
    if (word_chg) begin
      n.transmit_buffer_full = 1'b0;
      n.receive_buffer_full = 1'b0;
      n.receive_overflow_flag = 1'b0;
    end

    // -------------------------------------------------------------------------
    // Pin drive
    // -------------------------------------------------------------------------
    // (RULE_13) active phase per edge
    sck_act = (n.state == spi_port_pkg::ST_SHIFT) &&
              (cke_eff ? (n.cnt >= half) : (n.cnt < half));
    // (RULE_16) idle level
    n.pins.sck = r.pri.clock_polarity ^ (sck_act & ~ext_clk);
    // (RULE_01) pins claimed when on
    // (RULE_06) clock pin released
    n.pins.sck_oe = n.port_enable & ~ext_clk;
    n.pins.sdo = n.sdo;
    // (RULE_07) data-out disable
    n.pins.sdo_oe = n.port_enable & ~r.pri.data_out_disable & sel_ok;
    // (RULE_22) sync with or before bit
    fs_drive = (n.state == spi_port_pkg::ST_PRE) ||
               (r.frame_sync_edge && n.state == spi_port_pkg::ST_SHIFT &&
                n.bitn == 5'h00);
    // (RULE_21) polarity of driven sync
    n.pins.fs = r.frame_sync_polarity ? fs_drive : ~fs_drive;
    // (RULE_20) sync output as framed master
    n.pins.fs_oe = n.port_enable & r.framed_enable & ~r.frame_sync_direction;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      r <= '0;
      r.pri <= `RST_PRI;
      r.transmit_holding_register <= `RST_WORD;
      r.receive_holding_register <= `RST_WORD;
      r.state <= spi_port_pkg::ST_IDLE;
    end else begin
      r <= n;
    end
  end

  assign o_rdata = r.rdata;
  assign o_pins = r.pins;
  assign o_port_active = r.port_enable;

endmodule // spi_port

/* File: spi_port_chk.sv */
module spi_port_chk (
  // Clock and reset
  input wire logic                     i_clk,
  input wire logic                     i_reset,
  // Register port
  input wire spi_port_pkg::reg_req_t   i_bus,
  input wire logic [15:0]              o_rdata,
  // Serial side
  input wire logic                     i_idle,
  input wire logic                     i_sck,
  input wire logic                     i_sdi,
  input wire logic                     i_fs,
  input wire spi_port_pkg::pin_drive_t o_pins,
  input wire logic                     o_port_active
);
  logic wr0, wr1, rd0, rd1, rd2, rd3;

  assign wr0 = i_bus.wr && i_bus.addr == 2'h0;
  assign wr1 = i_bus.wr && i_bus.addr == 2'h1;
  assign rd0 = i_bus.rd && i_bus.addr == 2'h0;
  assign rd1 = i_bus.rd && i_bus.addr == 2'h1;
  assign rd2 = i_bus.rd && i_bus.addr == 2'h2;
  assign rd3 = i_bus.rd && i_bus.addr == 2'h3;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  chk_rdata_quiet: assert property (
    !$past(i_bus.rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read slot");
  chk_stat_reserved: assert property (
    $past(rd0) |-> (o_rdata & 16'h5FBC) == 16'h0000)
    else $error("unused status bits read nonzero");
  chk_ctrl_reserved: assert property (
    $past(rd1) |-> o_rdata[15:13] == 3'h0)
    else $error("unused control bits read nonzero");
  chk_frame_reserved: assert property (
    $past(rd2) |-> (o_rdata & 16'h1FFD) == 16'h0000)
    else $error("unused framing bits read nonzero");
  chk_stat_keeps: assert property (
    wr0 ##1 !i_bus.wr ##1 rd0 |=> o_rdata[15] == $past(i_bus.wdata[15], 3)
      && o_rdata[13] == $past(i_bus.wdata[13], 3))
    else $error("status control bits not kept");
  chk_ctrl_keeps: assert property (
    wr1 ##1 !i_bus.wr ##1 rd1 |=> o_rdata[12:0] == $past(i_bus.wdata[12:0], 3))
    else $error("control bits not kept");
  chk_rbf_clears: assert property (
    rd3 ##1 !i_bus.wr ##1 rd0 |=> !o_rdata[0])
    else $error("receive full not cleared by buffer read");
  chk_ovf_clears: assert property (
    wr0 && !i_bus.wdata[6] ##1 !i_bus.wr ##1 rd0 |=> !o_rdata[6])
    else $error("overflow not cleared by software");
  chk_pins_free: assert property (
    !o_port_active && $past(!o_port_active)
      |-> !(o_pins.sck_oe || o_pins.sdo_oe || o_pins.fs_oe))
    else $error("pins driven while port disabled");
  chk_active_follows: assert property (
    wr0 |=> o_port_active == $past(i_bus.wdata[15]))
    else $error("port active does not follow enable");

  cov_master_clock: cover property (o_pins.sck_oe && $changed(o_pins.sck));
  cov_slave_clock: cover property (o_port_active && $changed(i_sck));
  cov_overflow: cover property ($past(rd0) && o_rdata[6]);
endmodule // spi_port_chk

bind spi_port spi_port_chk u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_idle(i_idle), .i_sck(i_sck), .i_sdi(i_sdi), .i_fs(i_fs),
  .o_pins(o_pins), .o_port_active(o_port_active)
);

/* File: spi_port_consts.svh */
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register word addresses
// ---------------------------------------------------------------------------
`define ADDR_STATUS    2'h0
`define ADDR_CTRL_PRI  2'h1
`define ADDR_CTRL_FRM  2'h2
`define ADDR_BUFFER    2'h3

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define STAT_EN_BIT    15
`define STAT_SIDL_BIT  13
`define STAT_ROV_BIT   6
`define STAT_TBF_BIT   1
`define STAT_RBF_BIT   0
`define FRM_EN_BIT     15
`define FRM_DIR_BIT    14
`define FRM_POL_BIT    13
`define FRM_EDGE_BIT   1
`define PRI_WIDTH      13
`define PRI_CPD_BIT    12
`define PRI_WS_BIT     10
`define PRI_MST_BIT    5

// ---------------------------------------------------------------------------
// Reset values and timing counts
// ---------------------------------------------------------------------------
`define RST_WORD       16'h0000
`define RST_PRI        13'h0000
`define MSB_BYTE       4'h7
`define MSB_WORD       4'hF
`define SEC_BASE       4'h8
`define PERIOD_MIN     10'h002

`endif

/* File: spi_port_pkg.sv */
package spi_port_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_SHIFT} eng_state_t;

  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic clock_pin_disable;
    logic data_out_disable;
    logic word_size_select;
    logic input_sample_phase;
    logic clock_edge;
    logic slave_select_enable;
    logic clock_polarity;
    logic master_enable;
    logic [2:0] secondary_prescale;
    logic [1:0] primary_prescale;
  } ctrl_pri_t;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic sdo;
    logic sdo_oe;
    logic fs;
    logic fs_oe;
  } pin_drive_t;

  typedef struct packed {
    logic        port_enable;
    logic        idle_stop;
    logic        receive_overflow_flag;
    logic        transmit_buffer_full;
    logic        receive_buffer_full;
    ctrl_pri_t   pri;
    logic        framed_enable;
    logic        frame_sync_direction;
    logic        frame_sync_polarity;
    logic        frame_sync_edge;
    logic [15:0] transmit_holding_register;
    logic [15:0] receive_holding_register;
    logic [15:0] serial_shift_register;
    eng_state_t  state;
    logic [9:0]  cnt;
    logic [4:0]  bitn;
    logic        loaded;
    logic        frame_go;
    logic        sdo;
    logic [15:0] rdata;
    logic        sck_s1;
    logic        sck_s2;
    logic        sck_prev;
    logic        sdi_s1;
    logic        sdi_s2;
    logic        fs_s1;
    logic        fs_s2;
    pin_drive_t  pins;
  } port_state_t;

endpackage

/* File: spi_port_registers_modes_bench.sv */
module spi_port_registers_modes_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                     i_clk = 1'b0;
  logic                     i_reset = 1'b1;
  logic                     i_idle = 1'b0;
  logic                     i_fs = 1'b1;
  spi_port_pkg::reg_req_t   bus = '0;
  spi_port_pkg::pin_drive_t o_pins;
  logic [15:0]              o_rdata, far_rx;
  logic [15:0]              far_tx = 16'hC3A5;
  logic                     o_port_active, sck_line, sdi_line, sdo_line;
  logic                     far_drive = 1'b0;
  logic                     cpol = 1'b0;
  logic [4:0]               bits = 5'h08;
  int                       fail_count = 0;
  int                       comparisons = 0;
  int                       act_n = 0;
  int                       sdo_on = 0;
  int                       fs_on = 0;
  int                       far_edges;

  always #20 i_clk = ~i_clk;
  assign sdo_line = o_pins.sdo_oe ? o_pins.sdo : 1'bz;

  spi_port i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_bus(bus),
    .o_rdata(o_rdata), .i_idle(i_idle), .i_sck(sck_line), .i_sdi(sdi_line),
    .i_fs(i_fs), .o_pins(o_pins), .o_port_active(o_port_active));
  spi_far_end u_far (.i_drive(far_drive), .i_cpol(cpol), .i_bits(bits),
    .i_tx(far_tx), .i_sck(o_pins.sck), .i_sdo(sdo_line), .o_sck(sck_line),
    .o_sdi(sdi_line), .o_rx(far_rx), .o_edges(far_edges));

  always @(posedge i_clk) begin
    if (o_pins.sck_oe && o_pins.sck !== cpol) act_n <= act_n + 1;
    if (o_pins.sdo_oe) sdo_on <= sdo_on + 1;
    if (o_pins.fs_oe && o_pins.fs) fs_on <= fs_on + 1;
  end

  // ----
  // Bus tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus <= '0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus <= '0;
    #1 v = o_rdata;
    @(posedge i_clk);
  endtask

  task automatic wait_flag(input int b);
    logic [15:0] v;
    v = 16'h0000;
    for (int n = 0; n < 1200 && v[b] !== 1'b1; n++) rd(2'h0, v);
    check({15'h0000, v[b]}, 16'h0001);
  endtask

  // A polarity change looks like a clock edge to the far end, so it is
  // cleared only once the idle level has settled.
  task automatic setup(input logic [15:0] cfg);
    wr(2'h1, cfg);
    bits <= cfg[10] ? 5'h10 : 5'h08;
    cpol <= cfg[6];
    repeat (4) @(posedge i_clk);
    u_far.clear();
    act_n = 0;
    sdo_on = 0;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    logic [15:0] v;
    for (int a = 0; a < 4; a++) begin
      rd(2'(a), v);
      check(v, 16'h0000);
    end
    wr(2'h0, 16'hFFFF);
    rd(2'h0, v);
    check(v, 16'hA000);
    check({15'h0000, o_port_active}, 16'h0001);
    wr(2'h1, 16'hFFFF);
    rd(2'h1, v);
    check(v, 16'h1FFF);
    wr(2'h2, 16'hFFFF);
    rd(2'h2, v);
    check(v, 16'hE002);
    wr(2'h2, 16'h0000);
    wr(2'h0, 16'h8000);
    rd(2'h0, v);
    check(v, 16'h8000);
    $display("test registers done");
  endtask

  task automatic t_master(input logic [15:0] cfg, input logic [15:0] tx,
                          input int p);
    logic [15:0] v, m;
    m = cfg[10] ? 16'hFFFF : 16'h00FF;
    setup(cfg);
    wr(2'h3, tx);
    wait_flag(0);
    check(16'(act_n), 16'(bits * p / 2));
    check({15'h0000, o_pins.sck}, {15'h0000, cpol});
    check(16'(far_edges), {11'h000, bits});
    check(far_rx & m, tx & m);
    rd(2'h3, v);
    check(v, far_tx & m);
    rd(2'h0, v);
    check(v & 16'h0003, 16'h0000);
    $display("test master transfer done");
  endtask

  task automatic t_overflow();
    logic [15:0] v;
    setup(16'h0263);
    wr(2'h3, 16'h0011);
    wait_flag(0);
    u_far.clear();
    far_tx <= 16'h005A;
    wr(2'h3, 16'h0022);
    wait_flag(6);
    rd(2'h0, v);
    check(v & 16'h0043, 16'h0041);
    rd(2'h3, v);
    check(v, 16'h00A5);
    wr(2'h1, 16'h0663);
    rd(2'h0, v);
    check(v & 16'h0043, 16'h0000);
    $display("test overflow done");
  endtask

  task automatic t_framed();
    logic [15:0] v;
    wr(2'h2, 16'hA000);
    setup(16'h0063);
    fs_on = 0;
    wr(2'h3, 16'h003C);
    wait_flag(0);
    check(16'(fs_on), 16'h0008);
    check(16'(act_n), 16'h0020);
    check(far_rx & 16'h00FF, 16'h003C);
    rd(2'h3, v);
    wr(2'h2, 16'h0000);
    $display("test framed master done");
  endtask

  task automatic t_idle_pins();
    logic [15:0] v;
    setup(16'h0863);
    wr(2'h0, 16'hA000);
    i_idle <= 1'b1;
    wr(2'h3, 16'h00F0);
    repeat (40) @(posedge i_clk);
    rd(2'h0, v);
    check(v & 16'h0002, 16'h0002);
    check(16'(act_n), 16'h0000);
    i_idle <= 1'b0;
    wait_flag(0);
    check(16'(sdo_on), 16'h0000);
    check(16'(act_n), 16'h0020);
    check({15'h0000, o_pins.sck_oe}, 16'h0001);
    rd(2'h3, v);
    wr(2'h1, 16'h1063);
    repeat (3) @(posedge i_clk);
    check({15'h0000, o_pins.sck_oe}, 16'h0000);
    $display("test idle and pins done");
  endtask

  task automatic t_slave();
    logic [15:0] v;
    far_tx <= 16'h3CC3;
    // Sample phase and clock edge stay clear in slave mode.
    setup(16'h0400);
    far_drive <= 1'b1;
    repeat (2) @(posedge i_clk);
    wr(2'h3, 16'h96E1);
    u_far.clear();
    u_far.run();
    // The link clock runs on its own delays; rejoin the system clock before the bus.
    @(posedge i_clk);
    wait_flag(0);
    check(far_rx, 16'h96E1);
    rd(2'h3, v);
    check(v, 16'h3CC3);
    check({15'h0000, o_pins.sck_oe}, 16'h0000);
    $display("test slave receive done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    t_regs();
    t_master(16'h043A, 16'hA55A, 8);
    t_master(16'h0263, 16'h0096, 8);
    t_master(16'h003C, 16'h0069, 64);
    t_master(16'h0431, 16'h1E87, 64);
    t_overflow();
    t_framed();
    t_idle_pins();
    t_slave();
    final_report();
  end

  // The tests need some two and a half thousand cycles; the limit of 50000 cycles allows about twenty times that.
  initial begin
    #2000000;
    fail_count++;
    final_report();
  end
endmodule // spi_port_registers_modes_bench
